/* rtl/ccs_pkg.sv */
package ccs_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int CLK_MHZ            = 200;
    localparam int MEAS_MAX_US        = 50;
    localparam int MEAS_CYC           = MEAS_MAX_US * CLK_MHZ;
    localparam int LOAD_TIME_NS       = 1200000;
    localparam int LOAD_CYC           = LOAD_TIME_NS * CLK_MHZ / 1000;
    localparam int DELAY_STEP_US      = 500;
    localparam int DELAY_STEP_CYC     = DELAY_STEP_US * CLK_MHZ;
    localparam int DETECT_WIN_US      = 10;
    localparam int DETECT_WIN_CYC     = DETECT_WIN_US * CLK_MHZ;
    localparam int DITHER_STEP_US     = 1;
    localparam int DITHER_STEP_CYC    = DITHER_STEP_US * CLK_MHZ;
    localparam int DITHER_MAX_PCT     = 15;
    localparam int SYNC_LOW_TENTHS    = 7;
    localparam int SYNC_HIGH_TENTHS   = 11;
    localparam int SYNC_MAX_MHZ       = 24;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [7:0] OFF_CTRL0    = 8'h00;
    localparam logic [7:0] OFF_CTRL1    = 8'h04;
    localparam logic [7:0] OFF_CTRL2    = 8'h08;
    localparam logic [7:0] OFF_DELAY0   = 8'h0C;
    localparam logic [7:0] OFF_DELAY1   = 8'h10;
    localparam logic [7:0] OFF_DELAY2   = 8'h14;
    localparam logic [7:0] OFF_CONFIG   = 8'h18;
    localparam logic [7:0] OFF_PLL      = 8'h1C;
    localparam logic [7:0] OFF_MEAS_SEL = 8'h20;
    localparam logic [7:0] OFF_INT      = 8'h24;
    localparam logic [7:0] OFF_MASK     = 8'h28;
    localparam logic [7:0] OFF_LOAD1    = 8'h2C;
    localparam logic [7:0] OFF_LOAD2    = 8'h30;
    localparam logic [7:0] OFF_STATUS   = 8'h34;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int F_ON      = 0;
    localparam int F_PINSEL  = 1;
    localparam int F_FPWM    = 3;
    localparam int F_VSET    = 8;
    localparam int F_ILIM    = 12;
    localparam int F_DISCH   = 16;
    localparam int F_DON     = 0;
    localparam int F_DOFF    = 4;
    localparam int F_FREQ    = 8;
    localparam int F_MEAS    = 0;
    localparam int F_SYNC    = 1;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic       RST_DISCH   = 1'b1;
    localparam logic [1:0] RST_UP_VSET = 2'h1;
    localparam logic [4:0] RST_FREQ    = 5'h00;

    typedef enum logic [2:0] {
        ST_LOAD    = 3'b001,
        ST_STANDBY = 3'b010,
        ST_ACTIVE  = 3'b100
    } ccs_mode_e;

    typedef struct packed {
        logic [2:0]      enable;
        logic [1:0]      step_down_fpwm;
        logic            step_up_fpwm;
        logic [1:0][7:0] step_down_voltage_setting;
        logic [1:0]      step_up_voltage_setting;
        logic [1:0]      step_up_current_limit;
        logic            step_up_discharge_enable;
        logic            step_up_bypass;
    } ccs_conv_s;

    typedef struct packed {
        logic       use_external;
        logic       dither_active;
        logic [3:0] dither_code;
    } ccs_clk_s;

endpackage : ccs_pkg

/* rtl/ccs_top.sv */
// Decided for this implementation: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
// Overview of operation
// [R1] A write to the measurement select register starts a measurement of the chosen buck.
// [R2] The measured buck runs forced PWM while its measurement is running.
// [R3] A measurement always ends within 50 microseconds of its start.
// [R4] End of measurement sets the measurement-done flag.
// [R5] A set measurement-done mask keeps that flag off the interrupt output.
// [R6] Result is 9 bits: low byte in first register, top bit in second.
// [R7] One result step is 20 mA, full scale 10.22 A.
// [R8] Boost voltage code selects 4.9 V to 5.2 V in 0.1 V steps.
// [R9] Boost always runs forced PWM, never pulse-frequency mode.
// [R10] Boost normal or bypass mode is a factory setting, fixed in operation.
// [R11] Dither varies all three converter frequencies from 0.85 to 1.0 nominal.
// [R12] Dither acts only with its bit set and the PLL enable clear.
// [R13] A 5-bit field sets the nominal sync clock from 1 to 24 MHz.
// [R14] Sync clock is valid only within -30 to +10 percent of nominal.
// [R15] PLL enable clear: detector off, internal oscillator, no clock interrupt.
// [R16] PLL enable set: detector runs, clock appearing or vanishing raises the flag.
// [R17] Missing clock falls back to internal oscillator; flagged at load and activation.
// [R18] A set sync-clock mask keeps that flag off the interrupt output.
// [R19] Host waits 1.2 ms after reset release before any register access.
// [R20] After the default load the device enters standby and starts the watchdog.
// [R21] Enable bit off turns converter off; pin select 00 on, else follows a pin.
// [R22] Under pin control, start and stop wait their 4-bit delays.
// [R23] Delays do not apply when the enable bit itself switches a converter.
// [R24] After measuring, the buck returns to its own mode and the result is held.
module ccs_top #(
    parameter int MEAS_CYC_P  = ccs_pkg::MEAS_CYC,
    parameter int LOAD_CYC_P  = ccs_pkg::LOAD_CYC,
    parameter int DSTEP_CYC_P = ccs_pkg::DELAY_STEP_CYC
) (
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    input  wire logic                 enable_pin_one,
    input  wire logic                 enable_pin_two,
    input  wire logic                 enable_pin_three,
    input  wire logic                 sync_clock_input,
    input  wire logic [1:0][8:0]      step_down_load_current,
    input  wire logic                 factory_bypass_mode,
    output ccs_pkg::ccs_conv_s        conv,
    output ccs_pkg::ccs_clk_s         clk_sel,
    output ccs_pkg::ccs_mode_e        device_mode,
    output logic                      watchdog_run,
    output logic                      irq_n
);
    import ccs_pkg::*;

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [31:0]      hrdata;
        logic             hready;
        logic             rd_pend;
        logic             wr_pend;
        logic [7:0]       addr;
        logic [2:0]       on_bit;
        logic [2:0][1:0]  pin_select;
        logic [1:0]       fpwm_bit;
        logic [2:0][3:0]  on_delay;
        logic [2:0][3:0]  off_delay;
        logic             dither_enable;
        logic             pll_enable;
        logic [4:0]       sync_nominal_freq;
        logic             meas_sel;
        logic             meas_busy;
        logic [15:0]      meas_cnt;
        logic [8:0]       result;
        logic [1:0]       flags;
        logic [1:0]       mask;
        logic [20:0]      load_cnt;
        logic [2:0]       pin_s1;
        logic [2:0]       pin_s2;
        logic [2:0]       pin_s3;
        logic [2:0]       pin_lvl;
        logic [2:0][23:0] dcnt;
        logic             ck_s1;
        logic             ck_s2;
        logic             ck_s3;
        logic             ck_lvl;
        logic [8:0]       ck_edges;
        logic [11:0]      ck_win;
        logic             ck_valid;
        logic [7:0]       dith_pre;
        logic             dith_up;
        ccs_conv_s        conv;
        ccs_clk_s         clk;
        ccs_mode_e        mode;
        logic             irq_n;
        logic             wdog;
    } ccs_state_s;

    ccs_state_s r_reg;
    ccs_state_s r_next;

    // Selected pin level for a pin-select code; code 00 is never asked here
    function automatic logic pin_level(input logic [2:0] lvl, input logic [1:0] sel);
        logic res;
        res = 1'b0;
        case (sel)
            2'h1:    res = lvl[0];
            2'h2:    res = lvl[1];
            2'h3:    res = lvl[2];
            default: res = 1'b0;
        endcase
        return res;
    endfunction : pin_level

    function automatic logic [31:0] rd_mux(input ccs_state_s s, input logic [7:0] a);
        logic [31:0] d;
        logic [1:0]  k;
        d = 32'h0000_0000;
        k = 2'h0;
        case (a)
            OFF_CTRL0, OFF_CTRL1: begin
                k = (a == OFF_CTRL1) ? 2'h1 : 2'h0;
                d[F_ON]              = s.on_bit[k];
                d[F_PINSEL +: 2]     = s.pin_select[k];
                d[F_FPWM]            = s.fpwm_bit[k[0]];
                d[F_VSET +: 8]       = s.conv.step_down_voltage_setting[k[0]];
            end
            OFF_CTRL2: begin
                d[F_ON]              = s.on_bit[2];
                d[F_PINSEL +: 2]     = s.pin_select[2];
                d[F_FPWM]            = 1'b1;
                d[F_VSET +: 2]       = s.conv.step_up_voltage_setting;
                d[F_ILIM +: 2]       = s.conv.step_up_current_limit;
                d[F_DISCH]           = s.conv.step_up_discharge_enable;
            end
            OFF_DELAY0, OFF_DELAY1, OFF_DELAY2: begin
                k = 2'((a - OFF_DELAY0) >> 2);
                d[F_DON +: 4]        = s.on_delay[k];
                d[F_DOFF +: 4]       = s.off_delay[k];
            end
            OFF_CONFIG:   d[0] = s.dither_enable;
            OFF_PLL: begin
                d[0]                 = s.pll_enable;
                d[F_FREQ +: 5]       = s.sync_nominal_freq;
            end
            OFF_MEAS_SEL: d[0] = s.meas_sel;
            OFF_INT:      d[1:0] = s.flags;
            OFF_MASK:     d[1:0] = s.mask;
            OFF_LOAD1:    d[7:0] = s.result[7:0];
            OFF_LOAD2:    d[0] = s.result[8];
            OFF_STATUS:   d[9:0] = {s.conv.step_up_bypass, s.meas_busy, s.ck_valid, s.clk.use_external,
                                     s.conv.enable, s.mode};
            default:      d = 32'h0000_0000;
        endcase
        return d;
    endfunction : rd_mux

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic [2:0]  pins;
        logic [31:0] lim;
        logic        tgt;
        logic        win_end;
        logic        det_on;
        logic [31:0] fmhz;
        logic [1:0]  k;
        logic        meas_start;
        pins       = {enable_pin_three, enable_pin_two, enable_pin_one};
        lim        = 32'h0;
        tgt        = 1'b0;
        win_end    = 1'b0;
        det_on     = 1'b0;
        fmhz       = 32'h0;
        k          = 2'h0;
        meas_start = 1'b0;
        r_next     = r_reg;

        // Bus slave: writes have no wait state, reads take one so a write just before is seen
        r_next.wr_pend = 1'b0;
        if (r_reg.wr_pend) begin
            case (r_reg.addr)
                OFF_CTRL0, OFF_CTRL1: begin
                    k = (r_reg.addr == OFF_CTRL1) ? 2'h1 : 2'h0;
                    r_next.on_bit[k]                              = hwdata[F_ON];
                    r_next.pin_select[k]                          = hwdata[F_PINSEL +: 2];
                    r_next.fpwm_bit[k[0]]                         = hwdata[F_FPWM];
                    r_next.conv.step_down_voltage_setting[k[0]]   = hwdata[F_VSET +: 8];
                end
                OFF_CTRL2: begin
                    r_next.on_bit[2]                     = hwdata[F_ON];
                    r_next.pin_select[2]                 = hwdata[F_PINSEL +: 2];
                    r_next.conv.step_up_voltage_setting  = hwdata[F_VSET +: 2];   // [R8]
                    r_next.conv.step_up_current_limit    = hwdata[F_ILIM +: 2];
                    r_next.conv.step_up_discharge_enable = hwdata[F_DISCH];
                end
                OFF_DELAY0, OFF_DELAY1, OFF_DELAY2: begin
                    k = 2'((r_reg.addr - OFF_DELAY0) >> 2);
                    r_next.on_delay[k]  = hwdata[F_DON +: 4];
                    r_next.off_delay[k] = hwdata[F_DOFF +: 4];
                end
                OFF_CONFIG: r_next.dither_enable = hwdata[0];
                OFF_PLL: begin
                    r_next.pll_enable        = hwdata[0];
                    r_next.sync_nominal_freq = hwdata[F_FREQ +: 5];   // [R13]
                end
                OFF_MEAS_SEL: begin
                    r_next.meas_sel = hwdata[0];
                    meas_start      = 1'b1;   // [R1]
                end
                OFF_MASK: r_next.mask = hwdata[1:0];
                OFF_INT:  r_next.flags = r_reg.flags & ~hwdata[1:0];   // Cleared before any event, so a set wins
                default: ;
            endcase
        end
        if (r_reg.rd_pend) begin
            r_next.hrdata  = rd_mux(r_reg, r_reg.addr);
            r_next.hready  = 1'b1;
            r_next.rd_pend = 1'b0;
        end
        if (hready && hsel && htrans[1]) begin
            r_next.addr = {haddr[7:2], 2'b00};
            if (haddr[31:8] != 24'h0)
                r_next.addr = 8'hFC;   // Unmapped: reads zero, writes ignored
            if (hwrite) begin
                r_next.wr_pend = 1'b1;
            end else begin
                r_next.rd_pend = 1'b1;
                r_next.hready  = 1'b0;
            end
        end

        // Pin synchronisers: a level counts once the last two stages agree
        r_next.pin_s1 = pins;
        r_next.pin_s2 = r_reg.pin_s1;
        r_next.pin_s3 = r_reg.pin_s2;
        for (int i = 0; i < 3; i++) begin
            if (r_reg.pin_s2[i] == r_reg.pin_s3[i])
                r_next.pin_lvl[i] = r_reg.pin_s3[i];
        end
        r_next.ck_s1 = sync_clock_input;
        r_next.ck_s2 = r_reg.ck_s1;
        r_next.ck_s3 = r_reg.ck_s2;
        if (r_reg.ck_s2 == r_reg.ck_s3)
            r_next.ck_lvl = r_reg.ck_s3;

        // Converter enables
        for (int i = 0; i < 3; i++) begin
            if (!r_reg.on_bit[i] || r_reg.mode == ST_LOAD) begin
                r_next.conv.enable[i] = 1'b0;   // [R21]
                r_next.dcnt[i]        = 24'h0;
            end else if (r_reg.pin_select[i] == 2'h0) begin
                r_next.conv.enable[i] = 1'b1;   // [R21] [R23]
                r_next.dcnt[i]        = 24'h0;
            end else begin
                tgt = pin_level(r_reg.pin_lvl, r_reg.pin_select[i]);   // [R21]
                lim = (tgt ? 32'(r_reg.on_delay[i]) : 32'(r_reg.off_delay[i])) * 32'(DSTEP_CYC_P);
                if (tgt == r_reg.conv.enable[i]) begin
                    r_next.dcnt[i] = 24'h0;
                end else if (32'(r_reg.dcnt[i]) >= lim) begin
                    r_next.conv.enable[i] = tgt;   // [R22]
                    r_next.dcnt[i]        = 24'h0;
                end else begin
                    r_next.dcnt[i] = 24'(r_reg.dcnt[i] + 24'h1);   // [R22]
                end
            end
        end

        // Device mode; the watchdog runs from standby onward
        case (r_reg.mode)
            ST_LOAD: begin
                r_next.conv.step_up_bypass = factory_bypass_mode;   // [R10]
                r_next.load_cnt = 21'(r_reg.load_cnt + 21'h1);
                if (32'(r_reg.load_cnt) >= LOAD_CYC_P - 1) begin
                    r_next.mode = ST_STANDBY;   // [R20]
                    if (r_reg.pll_enable)
                        r_next.flags[F_SYNC] = 1'b1;   // [R17]
                end
            end
            ST_STANDBY: begin
                if (r_next.conv.enable != 3'h0) begin
                    r_next.mode = ST_ACTIVE;
                    if (r_reg.pll_enable && !r_reg.ck_valid)
                        r_next.flags[F_SYNC] = 1'b1;   // [R17]
                end
            end
            ST_ACTIVE: begin
                if (r_next.conv.enable == 3'h0)
                    r_next.mode = ST_STANDBY;
            end
            default: r_next.mode = ST_LOAD;
        endcase

        // Clock detector: count sync edges over a fixed window
        det_on = r_reg.pll_enable && r_reg.mode != ST_LOAD;   // [R15] [R16]
        fmhz   = 32'(r_reg.sync_nominal_freq) + 32'h1;
        if (fmhz > SYNC_MAX_MHZ)
            fmhz = SYNC_MAX_MHZ;
        if (!det_on) begin
            r_next.ck_valid = 1'b0;   // [R15]
            r_next.ck_edges = 9'h0;
            r_next.ck_win   = 12'h0;
        end else begin
            win_end       = 32'(r_reg.ck_win) >= DETECT_WIN_CYC - 1;
            r_next.ck_win = win_end ? 12'h0 : 12'(r_reg.ck_win + 12'h1);
            if (r_next.ck_lvl && !r_reg.ck_lvl && r_reg.ck_edges != 9'h1FF)
                r_next.ck_edges = 9'(r_reg.ck_edges + 9'h1);
            if (win_end) begin
                r_next.ck_edges = 9'h0;
                r_next.ck_valid = 32'(r_reg.ck_edges) * 10 >= fmhz * DETECT_WIN_US * SYNC_LOW_TENTHS &&
                                  32'(r_reg.ck_edges) * 10 <= fmhz * DETECT_WIN_US * SYNC_HIGH_TENTHS;   // [R14]
                if (r_next.ck_valid != r_reg.ck_valid)
                    r_next.flags[F_SYNC] = 1'b1;   // [R16]
            end
        end
        r_next.clk.use_external = r_next.ck_valid && r_reg.pll_enable;   // [R17]

        // Dither: triangle of 0 to 15 percent below nominal frequency
        r_next.clk.dither_active = r_reg.dither_enable && !r_reg.pll_enable;   // [R12]
        if (!r_next.clk.dither_active) begin
            r_next.clk.dither_code = 4'h0;
            r_next.dith_pre        = 8'h0;
            r_next.dith_up         = 1'b1;
        end else if (32'(r_reg.dith_pre) >= DITHER_STEP_CYC - 1) begin
            r_next.dith_pre = 8'h0;
            if (r_reg.dith_up) begin
                r_next.clk.dither_code = 4'(r_reg.clk.dither_code + 4'h1);   // [R11]
                r_next.dith_up = 32'(r_reg.clk.dither_code) < DITHER_MAX_PCT - 1;
            end else begin
                r_next.clk.dither_code = 4'(r_reg.clk.dither_code - 4'h1);   // [R11]
                r_next.dith_up = r_reg.clk.dither_code == 4'h1;
            end
        end else begin
            r_next.dith_pre = 8'(r_reg.dith_pre + 8'h1);
        end

        // Load current measurement
        if (meas_start) begin
            r_next.meas_busy = 1'b1;
            r_next.meas_cnt  = 16'h0;
        end else if (r_reg.meas_busy) begin
            r_next.meas_cnt = 16'(r_reg.meas_cnt + 16'h1);
            if (32'(r_reg.meas_cnt) >= MEAS_CYC_P - 1) begin
                r_next.meas_busy     = 1'b0;   // [R3] [R24]
                r_next.result        = step_down_load_current[r_reg.meas_sel];   // [R6] [R7]
                r_next.flags[F_MEAS] = 1'b1;   // [R4]
            end
        end
        for (int i = 0; i < 2; i++) begin
            r_next.conv.step_down_fpwm[i] = r_reg.fpwm_bit[i] ||
                                            (r_next.meas_busy && r_next.meas_sel == 1'(i));   // [R2] [R24]
        end
        r_next.conv.step_up_fpwm = 1'b1;   // [R9]

        r_next.irq_n = ~|(r_next.flags & ~r_next.mask);   // [R5] [R18]
        r_next.wdog  = r_next.mode != ST_LOAD;   // [R20]
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_reg                                <= '0;
            r_reg.hready                         <= 1'b1;
            r_reg.irq_n                          <= 1'b1;
            r_reg.mode                           <= ST_LOAD;
            r_reg.dith_up                        <= 1'b1;
            r_reg.sync_nominal_freq              <= RST_FREQ;
            r_reg.conv.step_up_discharge_enable  <= RST_DISCH;
            r_reg.conv.step_up_voltage_setting   <= RST_UP_VSET;
            r_reg.conv.step_up_fpwm              <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign hrdata       = r_reg.hrdata;
    assign hreadyout    = r_reg.hready;
    assign hresp        = 1'b0;
    assign conv         = r_reg.conv;
    assign clk_sel      = r_reg.clk;
    assign device_mode  = r_reg.mode;
    assign watchdog_run = r_reg.wdog;   // [R20]
    assign irq_n        = r_reg.irq_n;

endmodule : ccs_top

/* verif/ccs_checker.sv */
`timescale 1ns/10ps
// ****
// Port checks
// ****
module ccs_checker (
    input wire logic          hclk,
    input wire logic          hresetn,
    input wire logic          hsel,
    input wire logic [1:0]    htrans,
    input wire logic          hwrite,
    input wire logic          hready,
    input wire logic          hreadyout,
    input ccs_pkg::ccs_conv_s conv,
    input ccs_pkg::ccs_clk_s  clk_sel,
    input ccs_pkg::ccs_mode_e device_mode,
    input wire logic          watchdog_run
);
    import ccs_pkg::*;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire req = hsel && htrans[1] && hready;
    AST_BOOST_FPWM: assert property (conv.step_up_fpwm) else $error("boost left PWM");
    AST_WDOG: assert property (watchdog_run == (device_mode != ST_LOAD)) else $error("watchdog run wrong");
    AST_LOAD_OFF: assert property (device_mode == ST_LOAD |-> conv.enable == 3'h0) else $error("on in load");
    AST_DITHER: assert property (clk_sel.dither_active |-> !clk_sel.use_external)
        else $error("dither on sync");
    AST_BYPASS: assert property (device_mode != ST_LOAD |-> $stable(conv.step_up_bypass))
        else $error("bypass moved");
    AST_LOAD_RC: assert property (device_mode == ST_LOAD |-> !clk_sel.use_external)
        else $error("sync in load");
    AST_RD_WAIT: assert property (req && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
    AST_WR_NOWAIT: assert property (req && hwrite |=> hreadyout) else $error("write stalled");
    cover property (conv.step_down_fpwm != 2'h0);
    cover property (clk_sel.dither_active);
    cover property (clk_sel.use_external);
endmodule : ccs_checker
bind ccs_top ccs_checker u_chk (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .conv,
    .clk_sel, .device_mode, .watchdog_run);

/* verif/ccs_host_model.sv */
`timescale 1ns/10ps
// ****
// Host side: enable pins, 10 MHz sync clock, load current
// ****
module ccs_host_model (
    input wire logic        hclk,
    input wire logic [2:0]  pin_req,
    input wire logic        sync_on,
    output logic            enable_pin_one,
    output logic            enable_pin_two,
    output logic            enable_pin_three,
    output logic            sync_clock_input,
    output logic [1:0][8:0] step_down_load_current
);
    int cnt = 0;
    initial {enable_pin_three, enable_pin_two, enable_pin_one, sync_clock_input} = 4'h0;
    // Clock stands low when unused so the detector sees a true loss
    always @(posedge hclk) begin
        {enable_pin_three, enable_pin_two, enable_pin_one} <= pin_req;
        cnt <= (cnt == 9) ? 0 : cnt + 1;
        sync_clock_input <= sync_on & (sync_clock_input ^ (cnt == 9));
    end
    assign step_down_load_current = {9'h0C3, 9'h1A5};
endmodule : ccs_host_model

/* verif/testbench.sv */
`timescale 1ns/10ps
module testbench;
    import ccs_pkg::*;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, sync_on = 0, byp = 1;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
    logic [1:0] htrans = 0;
    logic [2:0] pin_req = 0;
    logic hreadyout, hresp, irq_n, wdr, enable_pin_one, enable_pin_two, enable_pin_three, sync_clock_input;
    logic [1:0][8:0] step_down_load_current;
    ccs_conv_s conv;
    ccs_clk_s clk_sel;
    ccs_mode_e mode;
    int err_total = 0, n_checks = 0;
    ccs_top #(.MEAS_CYC_P(100), .LOAD_CYC_P(50), .DSTEP_CYC_P(10)) dut (.hclk, .hresetn, .hsel, .haddr,
        .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .enable_pin_one, .enable_pin_two, .enable_pin_three, .sync_clock_input, .step_down_load_current,
        .factory_bypass_mode(byp), .conv, .clk_sel, .device_mode(mode), .watchdog_run(wdr), .irq_n);
    ccs_host_model host (.hclk, .pin_req, .sync_on, .enable_pin_one, .enable_pin_two, .enable_pin_three,
        .sync_clock_input, .step_down_load_current);
    task automatic end_of_test;
        if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask : cyc
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (!hreadyout);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (!hreadyout);
        q = hrdata;
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(0, a, 0);
        chk(q, exp);
    endtask : rd
    task automatic t_boot;
        chk(mode, ST_LOAD);
        cyc(60);
        chk(mode, ST_STANDBY);
        chk(wdr, 1);
        chk(conv.step_up_bypass, 1);
        byp <= 0;
        rd(OFF_CTRL2, 32'h10108);
        rd(8'h80, 0);
        chk(hresp, 0);
    endtask : t_boot
    task automatic t_meas;
        for (int b = 0; b < 2; b++) begin
            bus(1, OFF_MASK, b);
            bus(1, OFF_MEAS_SEL, b);
            cyc(3);
            chk(conv.step_down_fpwm, 2'h1 << b);
            cyc(100);
            chk(conv.step_down_fpwm, 0);
            chk(irq_n, b);
            rd(OFF_INT, 1);
            rd(OFF_LOAD1, b ? 32'hC3 : 32'hA5);
            rd(OFF_LOAD2, !b);
            bus(1, OFF_INT, 1);
        end
        bus(1, OFF_MASK, 0);
        chk(irq_n, 1);
    endtask : t_meas
    task automatic t_enable;
        bus(1, OFF_CTRL0, 32'h5A01);
        cyc(3);
        chk(conv.enable, 3'h1);
        chk(conv.step_down_voltage_setting[0], 8'h5A);
        chk(mode, ST_ACTIVE);
        rd(OFF_STATUS, 32'h20C);
        bus(1, OFF_CTRL0, 0);
        cyc(3);
        chk(conv.enable, 0);
        bus(1, OFF_DELAY1, 32'h21);
        for (int s = 1; s < 4; s++) begin
            bus(1, OFF_CTRL1, 1 | (s << 1));
            cyc(3);
            chk(conv.enable[1], 0);
            pin_req <= 3'h1 << (s - 1);
            cyc(12);
            chk(conv.enable[1], 0);
            cyc(10);
            chk(conv.enable[1], 1);
            pin_req <= 0;
            cyc(20);
            chk(conv.enable[1], 1);
            cyc(10);
            chk(conv.enable[1], 0);
        end
        bus(1, OFF_CTRL1, 0);
    endtask : t_enable
    task automatic t_clock;
        bus(1, OFF_CONFIG, 1);
        cyc(3);
        chk(clk_sel.dither_active, 1);
        cyc(3 * DITHER_STEP_CYC);
        chk(clk_sel.dither_code, 3);
        bus(1, OFF_PLL, 32'h901);
        cyc(3);
        chk(clk_sel.dither_active, 0);
        sync_on <= 1;
        cyc(4500);
        chk(clk_sel.use_external, 1);
        chk(irq_n, 0);
        rd(OFF_INT, 2);
        bus(1, OFF_MASK, 2);
        cyc(2);
        chk(irq_n, 1);
        bus(1, OFF_INT, 2);
        sync_on <= 0;
        cyc(4500);
        chk(clk_sel.use_external, 0);
        rd(OFF_INT, 2);
        chk(conv.step_up_bypass, 1);
    endtask : t_clock
    initial forever #2.5 hclk = ~hclk;
    initial begin
        #200us;
        err_total++;
        end_of_test;
    end
    initial begin
        cyc(4);
        hresetn <= 1;
        t_boot;
        t_meas;
        t_enable;
        t_clock;
        end_of_test;
    end
endmodule : testbench
